//--- til_pkg.sv
package til_pkg;
	// register indexes; byte address is four times the index
	localparam logic [15:0] IDX_PORT_A_DATA = 16'hF7C4;
	localparam logic [15:0] IDX_PORT_A_CTRL = 16'hF7C5;
	localparam logic [15:0] IDX_PORT_B_DATA = 16'hF7C6;
	localparam logic [15:0] IDX_PORT_B_CTRL = 16'hF7C7;
	localparam logic [15:0] IDX_MASK = 16'hF7C8;
	localparam logic [15:0] IDX_STATUS = 16'hF7C9;
	localparam int ADDR_W = 18;

	// port A peripheral register fields
	localparam int PA_NMI_PANEL_SRC = 0;
	localparam int PA_INT_OUT = 5;
	localparam int PA_LATCH_EN = 6;
	localparam int PA_NMI_BUTTON_SRC = 7;
	// port A and port B control register fields
	localparam int CA_SYNC_EN = 0;
	localparam int CA_SYNC_RISE = 1;
	localparam int CA_SW_LEVEL = 3;
	localparam int CA_MODE_LO = 4;
	localparam int CA_MODE_HI = 5;
	localparam int CA_SYNC_FLAG = 7;
	localparam int CB_STROBE_FLAG = 7;
	localparam logic [1:0] CA_MODE_SW = 2'h3;

	localparam logic [7:0] RST_PORT_A = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [2:0] RST_MASK = 3'h0;

	// vectors
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_DEFAULT = 16'hFFF8;
	localparam logic [15:0] VEC_LEVEL_BASE = 16'hFFE0;

	// power-on reset pulse length
	localparam int CLK_MHZ = 100;
	localparam int POR_TIME_US = 20;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
	localparam int POR_W = 12;
	localparam int SYNC_STAGES = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic level_seven;
		logic level_six;
		logic level_five;
		logic latchable_level;
		logic kbd_tx_empty;
		logic kbd_rx_full;
		logic kbd_error;
		logic pen;
		logic level_two;
		logic vsync;
		logic panel_nmi;
		logic button_n;
		logic power_nmi;
		logic variant;
	} til_pins_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [2:0] level;
		logic none_pending;
	} til_vector_type;

	typedef enum logic [1:0] {
		POR_ACTIVE = 2'b00,
		POR_DONE = 2'b01
	} til_por_type;
endpackage

//--- til_sync.sv
`timescale 1ns/1ps
module til_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

//--- til_interrupt_logic.sv
`timescale 1ns/1ps
module til_interrupt_logic (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [til_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [til_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire til_pkg::til_pins_type PINS,
	input wire logic VECTOR_FETCH,
	output til_pkg::til_vector_type VECTOR,
	output logic IRQ_N,
	output logic NMI_N,
	output logic SYS_RESET_N,
	output logic CPU_RESET_N,
	output logic INT_OUT_N
);
	import til_pkg::*;

	// idle levels of the pins; the button is active low, so a zero reset would fake a press
	localparam til_pins_type PIN_IDLE = til_pins_type'(14'h0004);

	til_pins_type pins;
	til_pins_type pins_d;
	til_pins_type pins_in;
	til_pins_type pins_q;

	assign pins_in = PINS ^ PIN_IDLE;
	assign pins = pins_q ^ PIN_IDLE;

	til_sync #(
		.WIDTH($bits(til_pins_type))
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d(pins_in),
		.q(pins_q)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pins_d <= PIN_IDLE;
		end else begin
			pins_d <= pins;
		end
	end

	// power-on reset pulse
	til_por_type por_state;
	logic [POR_W-1:0] por_count;
	wire por_end = (por_count == POR_W'(POR_CYCLES - 1));

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			por_state <= POR_ACTIVE;
			por_count <= '0;
		end else begin
			unique case (por_state)
				POR_ACTIVE: begin
					por_count <= por_count + POR_W'(1);
					if (por_end) begin
						por_state <= POR_DONE;
					end
				end
				POR_DONE: begin
					por_count <= por_count;
				end
				default: begin
					por_state <= POR_ACTIVE;
				end
			endcase
		end
	end

	wire por_active = (por_state != POR_DONE);
	wire variant = pins.variant;
	wire button = !pins.button_n;
	wire button_fall = pins_d.button_n && !pins.button_n;

	// registers
	logic [7:0] port_a;
	logic [7:0] port_a_ctrl;
	logic [7:0] port_b_ctrl;
	logic [2:0] mask;
	logic sync_flag;
	logic strobe_flag;
	logic level4_latch;

	// axi decode
	wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	wire rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
	wire [15:0] wr_idx = S_AXI_AWADDR[17:2];
	wire [15:0] rd_idx = S_AXI_ARADDR[17:2];
	wire wr_lane = S_AXI_WSTRB[0];
	wire wr_pa = wr_go && wr_lane && (wr_idx == IDX_PORT_A_DATA);
	wire wr_ca = wr_go && wr_lane && (wr_idx == IDX_PORT_A_CTRL);
	wire wr_cb = wr_go && wr_lane && (wr_idx == IDX_PORT_B_CTRL);
	wire wr_mask = wr_go && wr_lane && (wr_idx == IDX_MASK);
	wire wr_hit = (wr_idx == IDX_PORT_A_DATA) || (wr_idx == IDX_PORT_A_CTRL)
		|| (wr_idx == IDX_PORT_B_DATA) || (wr_idx == IDX_PORT_B_CTRL)
		|| (wr_idx == IDX_MASK) || (wr_idx == IDX_STATUS);
	wire rd_pa = rd_go && (rd_idx == IDX_PORT_A_DATA);
	wire rd_pb = rd_go && (rd_idx == IDX_PORT_B_DATA);
	wire [7:0] wdata = S_AXI_WDATA[7:0];

	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign S_AXI_ARREADY = rd_go;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			port_a <= RST_PORT_A;
			port_a_ctrl <= RST_CTRL;
			port_b_ctrl <= RST_CTRL;
			mask <= RST_MASK;
		end else begin
			if (wr_pa) begin
				port_a <= wdata;
			end
			if (wr_ca) begin
				port_a_ctrl <= wdata;
			end
			if (wr_cb) begin
				port_b_ctrl <= wdata;
			end
			if (wr_mask) begin
				mask <= wdata[2:0];
			end
		end
	end

	// frame sync edge flag, cleared by reading port A; a new edge wins
	wire sync_rise = pins.vsync && !pins_d.vsync;
	wire sync_fall = !pins.vsync && pins_d.vsync;
	wire sync_edge = port_a_ctrl[CA_SYNC_RISE] ? sync_rise : sync_fall;
	wire next_sync_flag = sync_edge || (sync_flag && !rd_pa);

	// button strobe flag, cleared by reading port B; a new strobe wins
	wire next_strobe_flag = (variant && button_fall) || (strobe_flag && !rd_pb);

	// level 4 pulse catcher
	wire next_level4_latch = port_a[PA_LATCH_EN] && (level4_latch || pins.latchable_level);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sync_flag <= 1'b0;
			strobe_flag <= 1'b0;
			level4_latch <= 1'b0;
		end else begin
			sync_flag <= next_sync_flag;
			strobe_flag <= next_strobe_flag;
			level4_latch <= next_level4_latch;
		end
	end

	// nmi source memory: last source seen stays readable
	logic nmi_from_button;
	logic nmi_from_power;
	wire nmi_button = !variant && button;
	wire nmi_power = variant && pins.power_nmi;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			nmi_from_button <= 1'b0;
			nmi_from_power <= 1'b0;
		end else begin
			if (nmi_button) begin
				nmi_from_button <= 1'b1;
			end else if (pins.panel_nmi) begin
				nmi_from_button <= 1'b0;
			end
			if (nmi_power) begin
				nmi_from_power <= 1'b1;
			end else if (pins.panel_nmi) begin
				nmi_from_power <= 1'b0;
			end
		end
	end

	// request levels
	logic [7:0] req;
	assign req[7] = pins.level_seven;
	assign req[6] = pins.level_six;
	assign req[5] = pins.level_five;
	assign req[4] = port_a[PA_LATCH_EN] ? (level4_latch || pins.latchable_level)
		: pins.latchable_level;
	assign req[3] = pins.kbd_tx_empty || pins.kbd_rx_full || pins.kbd_error
		|| pins.pen;
	assign req[2] = pins.level_two;
	assign req[1] = port_a_ctrl[CA_SYNC_EN] && sync_flag;
	assign req[0] = (port_a_ctrl[CA_MODE_HI:CA_MODE_LO] == CA_MODE_SW)
		&& !port_a_ctrl[CA_SW_LEVEL];

	// highest level at or above mask
	logic [2:0] top_level;
	logic any_valid;
	always_comb begin
		top_level = 3'h0;
		any_valid = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (req[i] && (3'(i) >= mask)) begin
				top_level = 3'(i);
				any_valid = 1'b1;
			end
		end
	end

	wire irq_any = any_valid || req[7];
	wire cpu_reset = por_active || (variant && button);

	// vector presented at fetch
	til_vector_type next_vector;
	always_comb begin
		next_vector = VECTOR;
		if (cpu_reset) begin
			next_vector.addr = VEC_RESET;
			next_vector.level = 3'h0;
			next_vector.none_pending = 1'b1;
		end else if (VECTOR_FETCH) begin
			next_vector.level = top_level;
			next_vector.none_pending = !any_valid;
			next_vector.addr = any_valid ? (VEC_LEVEL_BASE + {12'h000, top_level, 1'b0})
				: VEC_DEFAULT;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			VECTOR <= '{addr: VEC_RESET, level: 3'h0, none_pending: 1'b1};
			IRQ_N <= 1'b1;
			NMI_N <= 1'b1;
			SYS_RESET_N <= 1'b0;
			CPU_RESET_N <= 1'b0;
			INT_OUT_N <= 1'b1;
		end else begin
			VECTOR <= next_vector;
			IRQ_N <= !irq_any;
			NMI_N <= !(pins.panel_nmi || nmi_button || nmi_power);
			SYS_RESET_N <= !por_active;
			CPU_RESET_N <= !cpu_reset;
			INT_OUT_N <= !port_a[PA_INT_OUT];
		end
	end

	// read data
	logic [7:0] pa_read;
	always_comb begin
		pa_read = port_a;
		pa_read[PA_NMI_BUTTON_SRC] = variant ? port_a[PA_NMI_BUTTON_SRC]
			: nmi_from_button;
		pa_read[PA_NMI_PANEL_SRC] = variant ? nmi_from_power
			: port_a[PA_NMI_PANEL_SRC];
	end

	wire [7:0] ca_read = {sync_flag, port_a_ctrl[6:0]};
	wire [7:0] cb_read = {strobe_flag, port_b_ctrl[6:0]};
	wire [7:0] status_read = req;
	wire rd_hit = (rd_idx == IDX_PORT_A_DATA) || (rd_idx == IDX_PORT_A_CTRL)
		|| (rd_idx == IDX_PORT_B_DATA) || (rd_idx == IDX_PORT_B_CTRL)
		|| (rd_idx == IDX_MASK) || (rd_idx == IDX_STATUS);

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (rd_idx == IDX_PORT_A_DATA) begin
			rd_byte = pa_read;
		end else if (rd_idx == IDX_PORT_A_CTRL) begin
			rd_byte = ca_read;
		end else if (rd_idx == IDX_PORT_B_CTRL) begin
			rd_byte = cb_read;
		end else if (rd_idx == IDX_MASK) begin
			rd_byte = {5'h00, mask};
		end else if (rd_idx == IDX_STATUS) begin
			rd_byte = status_read;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_RDATA <= 32'h00000000;
		end else begin
			if (wr_go) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (rd_go) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				S_AXI_RDATA <= {24'h000000, rd_byte};
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule

//--- til_cpu_model.sv
`timescale 1ns/1ps
module til_cpu_model (
	input wire logic clk,
	input wire logic [13:0] set_pins,
	input wire logic fetch_go,
	output til_pkg::til_pins_type pins,
	output logic vector_fetch
);
	import til_pkg::*;
	initial begin
		pins = til_pins_type'(14'h0004);
		vector_fetch = 1'b0;
	end
	// sources and fetch strobe change just after the edge
	always @(posedge clk) begin
		pins <= til_pins_type'(set_pins);
		vector_fetch <= fetch_go;
	end
endmodule

//--- til_checker.sv
`timescale 1ns/1ps
module til_checker (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [til_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire til_pkg::til_pins_type PINS,
	input wire logic VECTOR_FETCH,
	input wire til_pkg::til_vector_type VECTOR,
	input wire logic IRQ_N,
	input wire logic NMI_N,
	input wire logic SYS_RESET_N,
	input wire logic CPU_RESET_N,
	input wire logic INT_OUT_N
);
	import til_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [11:0] por_cnt;
	logic wr_a;
	assign wr_a = S_AXI_AWREADY && S_AXI_WSTRB[0] && S_AXI_AWADDR[17:2] == IDX_PORT_A_DATA;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			por_cnt <= 12'h000;
		end else if (por_cnt != 12'hFFF) begin
			por_cnt <= por_cnt + 12'h001;
		end
	end
	property p_int_set;
		wr_a && S_AXI_WDATA[PA_INT_OUT] |-> ##[1:2] !INT_OUT_N;
	endproperty
	a_int_set: assert property (p_int_set) else $error("int out not low");
	property p_int_clr;
		wr_a && !S_AXI_WDATA[PA_INT_OUT] |-> ##[1:2] INT_OUT_N;
	endproperty
	a_int_clr: assert property (p_int_clr) else $error("int out not high");
	property p_por_low;
		int'(por_cnt) < POR_CYCLES |-> !SYS_RESET_N && !CPU_RESET_N;
	endproperty
	a_por_low: assert property (p_por_low) else $error("reset pulse short");
	property p_por_rise;
		$rose(SYS_RESET_N) |-> int'(por_cnt) >= POR_CYCLES && int'(por_cnt) <= POR_CYCLES + 3;
	endproperty
	a_por_rise: assert property (p_por_rise) else $error("reset pulse length");
	property p_lvl7;
		PINS.level_seven [*4] |=> !IRQ_N;
	endproperty
	a_lvl7: assert property (p_lvl7) else $error("level seven no irq");
	property p_nmi;
		PINS.panel_nmi [*4] |=> !NMI_N;
	endproperty
	a_nmi: assert property (p_nmi) else $error("panel nmi missing");
	property p_btn;
		(PINS.variant && !PINS.button_n) [*4] |=> !CPU_RESET_N;
	endproperty
	a_btn: assert property (p_btn) else $error("button no cpu reset");
	property p_vec_def;
		VECTOR_FETCH ##1 (CPU_RESET_N && VECTOR.none_pending) |-> VECTOR.addr == VEC_DEFAULT;
	endproperty
	a_vec_def: assert property (p_vec_def) else $error("default vector wrong");
	property p_vec_lvl;
		VECTOR_FETCH ##1 (CPU_RESET_N && !VECTOR.none_pending)
			|-> VECTOR.addr == VEC_LEVEL_BASE + {12'h000, VECTOR.level, 1'b0};
	endproperty
	a_vec_lvl: assert property (p_vec_lvl) else $error("level vector wrong");
	c_def: cover property (VECTOR_FETCH ##1 VECTOR.none_pending);
	c_lvl: cover property (VECTOR_FETCH ##1 !VECTOR.none_pending);
	c_por: cover property ($rose(SYS_RESET_N));
endmodule
bind til_interrupt_logic til_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
	.S_AXI_WSTRB(S_AXI_WSTRB), .PINS(PINS), .VECTOR_FETCH(VECTOR_FETCH), .VECTOR(VECTOR),
	.IRQ_N(IRQ_N), .NMI_N(NMI_N), .SYS_RESET_N(SYS_RESET_N), .CPU_RESET_N(CPU_RESET_N),
	.INT_OUT_N(INT_OUT_N));

//--- tb.sv
`timescale 1ns/1ps
module tb;
	import til_pkg::*;
	logic clk, rst_n, aw, w, b, ar, r, fgo, vf, awr, wr_y, bv, arr, rv;
	logic irq_n, nmi_n, sys_n, cpu_n, int_n;
	logic [17:0] awa, ara;
	logic [31:0] wd, rdd, d;
	logic [1:0] br, rr, rs;
	logic [13:0] sp;
	til_pins_type pins;
	til_vector_type vec;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	int pb[9] = '{13, 12, 11, 10, 9, 8, 7, 6, 5};
	int lv[9] = '{7, 6, 5, 4, 3, 3, 3, 3, 2};
	til_interrupt_logic DUT (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(w), .S_AXI_WREADY(wr_y), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(b), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(r),
		.PINS(pins), .VECTOR_FETCH(vf), .VECTOR(vec), .IRQ_N(irq_n), .NMI_N(nmi_n),
		.SYS_RESET_N(sys_n), .CPU_RESET_N(cpu_n), .INT_OUT_N(int_n));
	til_cpu_model u_cpu (.clk(clk), .set_pins(sp), .fetch_go(fgo), .pins(pins),
		.vector_fetch(vf));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] v);
		aw <= 1'b1;
		w <= 1'b1;
		b <= 1'b1;
		awa <= {i, 2'b00};
		wd <= {24'h000000, v};
		@(negedge clk);
		while (awr !== 1'b1) @(negedge clk);
		@(posedge clk);
		aw <= 1'b0;
		w <= 1'b0;
		@(negedge clk);
		while (bv !== 1'b1) @(negedge clk);
		rs = br;
		@(posedge clk);
	endtask
	task automatic rd(input logic [15:0] i);
		ar <= 1'b1;
		r <= 1'b1;
		ara <= {i, 2'b00};
		@(negedge clk);
		while (arr !== 1'b1) @(negedge clk);
		@(posedge clk);
		ar <= 1'b0;
		@(negedge clk);
		while (rv !== 1'b1) @(negedge clk);
		d = rdd;
		rs = rr;
		@(posedge clk);
	endtask
	// pins settle through model, sync and output stages
	task automatic pn(input logic [13:0] p);
		sp <= p;
		repeat (6) @(posedge clk);
	endtask
	task automatic fe;
		fgo <= 1'b1;
		@(posedge clk);
		fgo <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		rst_n = 1'b0;
		{aw, w, b, ar, r, fgo} = 6'h00;
		awa = 18'h00000;
		ara = 18'h00000;
		wd = 32'h00000000;
		sp = 14'h0004;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({sys_n, cpu_n, irq_n, int_n, nmi_n}, 5'h07);
		n = 0;
		while (sys_n !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(n >= POR_CYCLES && n <= POR_CYCLES + 3, 1'b1);
		chk(vec.addr, VEC_RESET);
		$display("power-on test done");
		rd(IDX_PORT_A_DATA);
		chk(d, RST_PORT_A);
		rd(IDX_MASK);
		chk(d, RST_MASK);
		wr(16'h0000, 8'h11);
		chk(rs, RESP_SLVERR);
		rd(16'h0000);
		chk({rs, d}, {RESP_SLVERR, 32'h0});
		wr(IDX_PORT_A_CTRL, 8'h80);
		rd(IDX_PORT_A_CTRL);
		chk(d, 32'h0);
		wr(IDX_PORT_A_DATA, 8'h20);
		repeat (2) @(posedge clk);
		chk(int_n, 1'b0);
		wr(IDX_PORT_A_DATA, 8'h00);
		repeat (2) @(posedge clk);
		chk(int_n, 1'b1);
		$display("register test done");
		for (int k = 0; k < 9; k++) begin
			pn(14'h0004 | (14'h0001 << pb[k]));
			chk(irq_n, 1'b0);
			rd(IDX_STATUS);
			chk(d, 32'h1 << lv[k]);
			fe;
			chk({vec.none_pending, vec.addr}, VEC_LEVEL_BASE + 2 * lv[k]);
		end
		pn(14'h0004);
		wr(IDX_MASK, 8'h07);
		pn(14'h0024);
		chk(irq_n, 1'b1);
		fe;
		chk({vec.none_pending, vec.addr}, {1'b1, VEC_DEFAULT});
		pn(14'h2004);
		chk(irq_n, 1'b0);
		pn(14'h0004);
		wr(IDX_MASK, 8'h00);
		$display("level test done");
		wr(IDX_PORT_A_DATA, 8'h40);
		sp <= 14'h0404;
		repeat (3) @(posedge clk);
		pn(14'h0004);
		rd(IDX_STATUS);
		chk(d[4], 1'b1);
		wr(IDX_PORT_A_DATA, 8'h00);
		rd(IDX_STATUS);
		chk(d[4], 1'b0);
		wr(IDX_PORT_A_CTRL, 8'h38);
		rd(IDX_STATUS);
		chk(d[0], 1'b0);
		wr(IDX_PORT_A_CTRL, 8'h30);
		rd(IDX_STATUS);
		chk(d[0], 1'b1);
		fe;
		chk(vec.addr, VEC_LEVEL_BASE);
		wr(IDX_PORT_A_CTRL, 8'h02);
		pn(14'h0014);
		rd(IDX_STATUS);
		chk(d[1], 1'b0);
		pn(14'h0004);
		rd(IDX_PORT_A_DATA);
		wr(IDX_PORT_A_CTRL, 8'h03);
		pn(14'h0014);
		rd(IDX_STATUS);
		chk(d[1], 1'b1);
		rd(IDX_PORT_A_DATA);
		pn(14'h0004);
		rd(IDX_STATUS);
		chk(d[1], 1'b0);
		$display("source test done");
		pn(14'h000C);
		chk(nmi_n, 1'b0);
		rd(IDX_PORT_A_DATA);
		chk(d[7], 1'b0);
		pn(14'h0000);
		chk(nmi_n, 1'b0);
		rd(IDX_PORT_A_DATA);
		chk(d[7], 1'b1);
		pn(14'h0007);
		chk(nmi_n, 1'b0);
		rd(IDX_PORT_A_DATA);
		chk(d[0], 1'b1);
		pn(14'h000D);
		rd(IDX_PORT_A_DATA);
		chk(d[0], 1'b0);
		pn(14'h0001);
		chk(cpu_n, 1'b0);
		pn(14'h0005);
		rd(IDX_PORT_B_CTRL);
		chk(d[7], 1'b1);
		$display("nmi test done");
		end_of_test;
	end
endmodule
